/* rcr_pkg.sv */
// constants, register map and state codes of the repeater register bank
package rcr_pkg;
   localparam int BYTE_W = 8;
   localparam int PIN_W  = 9;
   // register offsets
   localparam logic [7:0] REG_STRAP_LOAD   = 8'h00;
   localparam logic [7:0] REG_IDLE_LOSS    = 8'h01;
   localparam logic [7:0] REG_LOSS_OVR_PD  = 8'h02;
   localparam logic [7:0] REG_MODE_TXOFF   = 8'h04;
   localparam logic [7:0] REG_SLAVE_CRC_LO = 8'h05;
   localparam logic [7:0] REG_CRC_CTRL     = 8'h06;
   // reset values
   localparam logic [7:0] RST_STRAP_LOAD   = 8'h00;
   localparam logic [7:0] RST_IDLE_LOSS    = 8'h00;
   localparam logic [7:0] RST_LOSS_OVR_PD  = 8'h00;
   localparam logic [7:0] RST_MODE_TXOFF   = 8'h00;
   localparam logic [7:0] RST_SLAVE_CRC_LO = 8'h00;
   localparam logic [7:0] RST_CRC_CTRL     = 8'h10;
   // field positions
   localparam int ID_SPARE_BIT = 7;
   localparam int STRAP_LSB    = 3;
   localparam int LOADING_BIT  = 2;
   localparam int TALK_A_BIT   = 7;
   localparam int TALK_B_BIT   = 6;
   localparam int LOS_SEL_BIT  = 2;
   localparam int LOS_OVR_BIT  = 5;
   localparam int LOS_VAL_BIT  = 4;
   localparam int TX_OVR_BIT   = 5;
   localparam int TX_A_BIT     = 4;
   localparam int TX_B_BIT     = 3;
   localparam int CRC_OFF_BIT  = 3;
   localparam int CRC_TRIG_BIT = 0;
   // serial address upper bits, low four come from the straps
   localparam logic [2:0] SMB_ADDR_HI = 3'h5;
   localparam logic [7:0] CRC_POLY    = 8'h07;
   // edges after reset release before the synchronised straps are valid
   localparam logic [1:0] STRAP_CAPT  = 2'h2;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_AACK  = 9'h004,
      ST_PTR   = 9'h008,
      ST_PACK  = 9'h010,
      ST_WDATA = 9'h020,
      ST_WACK  = 9'h040,
      ST_RDATA = 9'h080,
      ST_RACK  = 9'h100
   } rcr_state_e;
endpackage

/* rcr_sync.sv */
// two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
module rcr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end
   assign q_o = sync_q;
endmodule

/* rcr_crc8.sv */
// crc-8 over the three data-path control bytes
`timescale 1ns/10ps
module rcr_crc8 #(
   parameter logic [7:0] POLY = rcr_pkg::CRC_POLY
) (
   input  wire logic [rcr_pkg::BYTE_W-1:0] b0_i,
   input  wire logic [rcr_pkg::BYTE_W-1:0] b1_i,
   input  wire logic [rcr_pkg::BYTE_W-1:0] b2_i,
   output logic      [rcr_pkg::BYTE_W-1:0] crc_o
);
   import rcr_pkg::*;
   function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                           input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ POLY) : (r << 1);
      end
      return r;
   endfunction
   assign crc_o = crc_byte(crc_byte(crc_byte(8'h00, b0_i), b1_i), b2_i);
endmodule

/* rcr_regs.sv */
// serial-managed control and status register bank of a two-channel repeater
`timescale 1ns/10ps
// Notes on behaviour
// - id register bits 6:3 are read-only and show the sampled straps
// - id register bit 2 reads 1 while eeprom load runs, 0 when done
// - register 0x01 bit 7 turns on continuous talk for the first channel
// - register 0x01 bit 6 turns on continuous talk for second channel
// - register 0x01 bit 2 picks loss monitor source: 1 second, 0 first
// - 0x02 bit 5 set: loss output follows bit 4 (0 flags loss)
// - 0x04 bit 5 set: bits 4 and 3 give per-channel transmit off
// - 0x04 bit 5 clear: both transmitters follow the transmit off pin
// - with crc checking on and eeprom load done, writes reach data path only after matching crc
module rcr_regs #(
   parameter logic [2:0] ADDR_HI = rcr_pkg::SMB_ADDR_HI
) (
   input  wire logic                       ref_clk_i,
   input  wire logic                       reset_n_i,
   input  wire logic [3:0]                 strap_addr_i,
   input  wire logic                       scl_i,
   input  wire logic                       sda_i,
   output logic                            sda_o,
   output logic                            sda_oe_n_o,
   input  wire logic                       ee_wr_i,
   input  wire logic [rcr_pkg::BYTE_W-1:0] ee_addr_i,
   input  wire logic [rcr_pkg::BYTE_W-1:0] ee_data_i,
   input  wire logic                       ee_done_i,
   input  wire logic                       signal_loss_first_i,
   input  wire logic                       signal_loss_second_i,
   input  wire logic                       transmit_off_pin_i,
   output logic                            cont_talk_first_o,
   output logic                            cont_talk_second_o,
   output logic                            signal_loss_o,
   output logic                            transmit_off_first_o,
   output logic                            transmit_off_second_o
);
   import rcr_pkg::*;

   logic [PIN_W-1:0] pins_s;
   rcr_sync #(.W(PIN_W)) u_sync (
      .clk_i     (ref_clk_i),
      .reset_n_i (reset_n_i),
      .d_i       ({strap_addr_i, scl_i, sda_i, signal_loss_first_i,
                   signal_loss_second_i, transmit_off_pin_i}),
      .q_o       (pins_s)
   );
   wire [3:0] strap_w = pins_s[8:5];
   wire       scl_w   = pins_s[4];
   wire       sda_w   = pins_s[3];
   wire       los1_w  = pins_s[2];
   wire       los2_w  = pins_s[1];
   wire       txpin_w = pins_s[0];

   // previous bus levels for edge and start/stop detection
   logic scl_p_q;
   logic sda_p_q;
   wire rise_w  = scl_w & ~scl_p_q;
   wire fall_w  = ~scl_w & scl_p_q;
   wire start_w = scl_w & scl_p_q & sda_p_q & ~sda_w;
   wire stop_w  = scl_w & scl_p_q & ~sda_p_q & sda_w;

   // strap capture, waits for the synchroniser to fill after reset
   logic [1:0] strap_cnt_q;
   logic [3:0] strap_q;
   logic       loading_q;

   // software-visible registers
   logic       id7_q;
   logic [7:0] r01_q;
   logic [7:0] r02_q;
   logic [7:0] r04_q;
   logic [7:0] r05_q;
   logic [7:0] r06_q;
   logic       trig_q;
   // copies that actually steer the data path
   logic [7:0] a01_q;
   logic [7:0] a02_q;
   logic [7:0] a04_q;

   // serial target engine
   rcr_state_e st_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic       rw_q;
   logic       ack_on_q;
   logic [7:0] ptr_q;
   logic       sda_oe_n_q;
   logic       smb_wr_q;
   logic [7:0] smb_wadr_q;
   logic [7:0] smb_wdat_q;

   logic cont_talk_first_q;
   logic cont_talk_second_q;
   logic signal_loss_q;
   logic tx_first_q;
   logic tx_second_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   // read view; unmapped offsets read zero
   wire [7:0] id_rd_w = {id7_q, strap_q, loading_q, 2'b00};
   wire [7:0] rd_w =
      hit(ptr_q, REG_STRAP_LOAD)   ? id_rd_w :
      hit(ptr_q, REG_IDLE_LOSS)    ? r01_q :
      hit(ptr_q, REG_LOSS_OVR_PD)  ? r02_q :
      hit(ptr_q, REG_MODE_TXOFF)   ? r04_q :
      hit(ptr_q, REG_SLAVE_CRC_LO) ? r05_q :
      hit(ptr_q, REG_CRC_CTRL)     ? r06_q : 8'h00;

   // eeprom preload takes the write port over the serial host
   wire       wr_en_w  = ee_wr_i | smb_wr_q;
   wire [7:0] wr_adr_w = ee_wr_i ? ee_addr_i : smb_wadr_q;
   wire [7:0] wr_dat_w = ee_wr_i ? ee_data_i : smb_wdat_q;
   wire wr00_w = wr_en_w & hit(wr_adr_w, REG_STRAP_LOAD);
   wire wr01_w = wr_en_w & hit(wr_adr_w, REG_IDLE_LOSS);
   wire wr02_w = wr_en_w & hit(wr_adr_w, REG_LOSS_OVR_PD);
   wire wr04_w = wr_en_w & hit(wr_adr_w, REG_MODE_TXOFF);
   wire wr05_w = wr_en_w & hit(wr_adr_w, REG_SLAVE_CRC_LO);
   wire wr06_w = wr_en_w & hit(wr_adr_w, REG_CRC_CTRL);

   logic [7:0] crc_w;
   rcr_crc8 #(.POLY(CRC_POLY)) u_crc (
      .b0_i  (r01_q),
      .b1_i  (r02_q),
      .b2_i  (r04_q),
      .crc_o (crc_w)
   );
   wire crc_off_w = r06_q[CRC_OFF_BIT];
   wire crc_ok_w  = trig_q & (crc_w == r05_q);
   wire commit_w  = crc_off_w | loading_q | crc_ok_w;

   wire addr_ok_w = (sh_q[6:0] == {ADDR_HI, strap_q});
   wire los_sel_w = a01_q[LOS_SEL_BIT] ? los2_w : los1_w;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_p_q     <= 1'b1;
         sda_p_q     <= 1'b1;
         strap_cnt_q <= 2'h0;
         strap_q     <= 4'h0;
         loading_q   <= 1'b1;
      end else begin
         scl_p_q <= scl_w;
         sda_p_q <= sda_w;
         if (strap_cnt_q != STRAP_CAPT + 2'h1) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         if (strap_cnt_q == STRAP_CAPT) begin
            strap_q <= strap_w;
         end
         if (ee_done_i) begin
            loading_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         id7_q  <= RST_STRAP_LOAD[ID_SPARE_BIT];
         r01_q  <= RST_IDLE_LOSS;
         r02_q  <= RST_LOSS_OVR_PD;
         r04_q  <= RST_MODE_TXOFF;
         r05_q  <= RST_SLAVE_CRC_LO;
         r06_q  <= RST_CRC_CTRL;
         trig_q <= 1'b0;
      end else begin
         if (wr00_w) id7_q <= wr_dat_w[ID_SPARE_BIT];
         if (wr01_w) r01_q <= wr_dat_w;
         if (wr02_w) r02_q <= wr_dat_w;
         if (wr04_w) r04_q <= wr_dat_w;
         if (wr05_w) r05_q <= wr_dat_w;
         // trigger bit clears itself and is seen as a one-cycle pulse
         if (wr06_w) r06_q <= {wr_dat_w[7:1], 1'b0};
         trig_q <= wr06_w & wr_dat_w[CRC_TRIG_BIT];
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         a01_q <= RST_IDLE_LOSS;
         a02_q <= RST_LOSS_OVR_PD;
         a04_q <= RST_MODE_TXOFF;
      end else if (commit_w) begin
         a01_q <= r01_q;
         a02_q <= r02_q;
         a04_q <= r04_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cont_talk_first_q  <= 1'b0;
         cont_talk_second_q <= 1'b0;
         signal_loss_q      <= 1'b0;
         tx_first_q         <= 1'b0;
         tx_second_q        <= 1'b0;
      end else begin
         cont_talk_first_q  <= a01_q[TALK_A_BIT];
         cont_talk_second_q <= a01_q[TALK_B_BIT];
         signal_loss_q <= a02_q[LOS_OVR_BIT] ? ~a02_q[LOS_VAL_BIT]
                                             : los_sel_w;
         tx_first_q  <= a04_q[TX_OVR_BIT] ? a04_q[TX_A_BIT]
                                          : txpin_w;
         tx_second_q <= a04_q[TX_OVR_BIT] ? a04_q[TX_B_BIT]
                                          : txpin_w;
      end
   end

   // bits are sampled on scl rise and driven after scl fall
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q       <= ST_IDLE;
         bit_q      <= 3'h0;
         sh_q       <= 8'h00;
         rw_q       <= 1'b0;
         ack_on_q   <= 1'b0;
         ptr_q      <= 8'h00;
         sda_oe_n_q <= 1'b1;
         smb_wr_q   <= 1'b0;
         smb_wadr_q <= 8'h00;
         smb_wdat_q <= 8'h00;
      end else begin
         smb_wr_q <= 1'b0;
         if (start_w) begin
            st_q       <= ST_ADDR;
            bit_q      <= 3'h0;
            ack_on_q   <= 1'b0;
            sda_oe_n_q <= 1'b1;
         end else if (stop_w) begin
            st_q       <= ST_IDLE;
            sda_oe_n_q <= 1'b1;
         end else begin
            case (st_q)
               ST_ADDR, ST_PTR, ST_WDATA: if (rise_w) begin
                  sh_q  <= {sh_q[6:0], sda_w};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == LAST_BIT) begin
                     if (st_q == ST_ADDR) begin
                        rw_q <= sda_w;
                        st_q <= addr_ok_w ? ST_AACK : ST_IDLE;
                     end else if (st_q == ST_PTR) begin
                        ptr_q <= {sh_q[6:0], sda_w};
                        st_q  <= ST_PACK;
                     end else begin
                        smb_wr_q   <= 1'b1;
                        smb_wadr_q <= ptr_q;
                        smb_wdat_q <= {sh_q[6:0], sda_w};
                        ptr_q      <= ptr_q + 8'h01;
                        st_q       <= ST_WACK;
                     end
                  end
               end
               ST_AACK, ST_PACK, ST_WACK: if (fall_w) begin
                  ack_on_q   <= ~ack_on_q;
                  sda_oe_n_q <= ack_on_q;
                  bit_q      <= 3'h0;
                  if (ack_on_q) begin
                     if (st_q == ST_AACK && rw_q) begin
                        sh_q       <= rd_w;
                        sda_oe_n_q <= rd_w[7];
                        st_q       <= ST_RDATA;
                     end else begin
                        st_q <= (st_q == ST_AACK) ? ST_PTR : ST_WDATA;
                     end
                  end
               end
               ST_RDATA: if (fall_w) begin
                  if (bit_q == LAST_BIT) begin
                     sda_oe_n_q <= 1'b1;
                     st_q       <= ST_RACK;
                  end else begin
                     sh_q       <= {sh_q[6:0], 1'b0};
                     sda_oe_n_q <= sh_q[6];
                     bit_q      <= bit_q + 3'h1;
                  end
               end
               ST_RACK: if (rise_w) begin
                  // a not-acknowledge ends the read burst
                  if (sda_w) st_q <= ST_IDLE;
                  else ptr_q <= ptr_q + 8'h01;
               end else if (fall_w) begin
                  sh_q       <= rd_w;
                  sda_oe_n_q <= rd_w[7];
                  bit_q      <= 3'h0;
                  st_q       <= ST_RDATA;
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // open-drain: only ever pulls low
   assign sda_o                 = 1'b0;
   assign sda_oe_n_o            = sda_oe_n_q;
   assign cont_talk_first_o     = cont_talk_first_q;
   assign cont_talk_second_o    = cont_talk_second_q;
   assign signal_loss_o         = signal_loss_q;
   assign transmit_off_first_o  = tx_first_q;
   assign transmit_off_second_o = tx_second_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_strap_view: assert property (
      strap_cnt_q == STRAP_CAPT |=> id_rd_w[6:3] == $past(strap_w))
      else $error("strap field does not show captured straps");
   a_load_flag: assert property (
      $fell(id_rd_w[LOADING_BIT]) |-> $past(ee_done_i))
      else $error("load flag fell without load done");
   a_talk_first: assert property (
      wr01_w && crc_off_w && !loading_q ##1 !wr01_w ##1 !wr01_w
      |=> cont_talk_first_o == $past(wr_dat_w[TALK_A_BIT], 3))
      else $error("first channel talk enable not applied");
   a_talk_second: assert property (
      wr01_w && crc_off_w && !loading_q ##1 !wr01_w ##1 !wr01_w
      |=> cont_talk_second_o == $past(wr_dat_w[TALK_B_BIT], 3))
      else $error("second channel talk enable not applied");
   a_loss_select: assert property (
      !a02_q[LOS_OVR_BIT] |=> signal_loss_o ==
         ($past(a01_q[LOS_SEL_BIT]) ? $past(los2_w) : $past(los1_w)))
      else $error("loss output not from selected channel");
   a_loss_override: assert property (
      a02_q[LOS_OVR_BIT] |=> signal_loss_o != $past(a02_q[LOS_VAL_BIT]))
      else $error("loss override value not applied");
   a_txoff_reg: assert property (
      a04_q[TX_OVR_BIT] |=> transmit_off_first_o == $past(a04_q[TX_A_BIT])
         && transmit_off_second_o == $past(a04_q[TX_B_BIT]))
      else $error("transmit off not from register bits");
   a_txoff_pin: assert property (
      !a04_q[TX_OVR_BIT] |=> transmit_off_first_o == $past(txpin_w)
         && transmit_off_second_o == $past(txpin_w))
      else $error("transmit off not from pin");
   a_crc_gate: assert property (
      !crc_off_w && !loading_q && !crc_ok_w |=> $stable(a01_q)
         && $stable(a02_q) && $stable(a04_q))
      else $error("data path changed without matching crc");
   a_crc_commit: assert property (
      crc_ok_w |=> a01_q == $past(r01_q) && a04_q == $past(r04_q))
      else $error("matching crc did not commit");

   c_smb_write: cover property (smb_wr_q && hit(smb_wadr_q, REG_IDLE_LOSS));
   c_smb_read:  cover property (st_q == ST_RACK && rise_w && !sda_w);
   c_crc_match: cover property (crc_ok_w && !crc_off_w);
   c_load_done: cover property ($fell(loading_q));
endmodule

/* rcr_host.sv */
// serial management host model driving the two-wire target port
`timescale 1ns/10ps
module rcr_host #(
   parameter int HALF = 12
) (
   input  wire logic       clk_i,
   input  wire logic [6:0] dev_addr_i,
   input  wire logic       sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // sda_o high releases the line, the pull-up then reads as 1
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // sda moves a few cycles after scl falls so the synced pins never
   // see both change in one cycle and mistake it for start or stop
   task automatic start_cond();
      wait_cyc(4);
      sda_o = 1'b1;
      wait_cyc(HALF);
      scl_o = 1'b1;
      wait_cyc(HALF);
      sda_o = 1'b0;
      wait_cyc(HALF);
      scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      wait_cyc(4);
      sda_o = 1'b0;
      wait_cyc(HALF);
      scl_o = 1'b1;
      wait_cyc(HALF);
      sda_o = 1'b1;
      wait_cyc(HALF);
   endtask

   // line sampled late in the high phase, well after the target's delay
   task automatic xfer_bit(input logic b, output logic seen);
      wait_cyc(4);
      sda_o = b;
      wait_cyc(HALF);
      scl_o = 1'b1;
      wait_cyc(HALF);
      seen = sda_i;
      scl_o = 1'b0;
   endtask

   // ninth bit is always released: target ack on writes, host nack on reads
   task automatic xfer_byte(input logic [7:0] b, output logic [7:0] got,
                            output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(b[i], got[i]);
      end
      xfer_bit(1'b1, seen);
      ack = ~seen;
   endtask

   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data,
                            output logic ok);
      logic [7:0] g;
      logic       a0;
      logic       a1;
      logic       a2;
      start_cond();
      xfer_byte({dev_addr_i, 1'b0}, g, a0);
      xfer_byte(ptr, g, a1);
      xfer_byte(data, g, a2);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask

   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data,
                           output logic ok);
      logic [7:0] g;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       na;
      start_cond();
      xfer_byte({dev_addr_i, 1'b0}, g, a0);
      xfer_byte(ptr, g, a1);
      start_cond();
      xfer_byte({dev_addr_i, 1'b1}, g, a2);
      xfer_byte(8'hff, data, na);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask
endmodule

/* repeater_control_registers_tb.sv */
// self-checking bench for the repeater register bank
`timescale 1ns/10ps
module repeater_control_registers_tb;
   import rcr_pkg::*;
   localparam logic [3:0] STRAPS   = 4'ha;
   // second strap set, applied across a mid-run reset
   localparam logic [3:0] STRAPS_B = 4'h5;
   logic [3:0] straps;
   logic       ref_clk_i;
   logic       reset_n_i;
   logic       scl;
   logic       host_sda;
   logic       dut_sda;
   logic       dut_oe_n;
   logic       ee_wr;
   logic [7:0] ee_addr;
   logic [7:0] ee_data;
   logic       ee_done;
   logic       loss_a;
   logic       loss_b;
   logic       tx_pin;
   wire  [4:0] outs;
   wire        sda_line = host_sda & (dut_oe_n | dut_sda);
   int         fail_count;
   int         check_count;

   rcr_regs i_rcr_regs (
      .ref_clk_i            (ref_clk_i),
      .reset_n_i            (reset_n_i),
      .strap_addr_i         (straps),
      .scl_i                (scl),
      .sda_i                (sda_line),
      .sda_o                (dut_sda),
      .sda_oe_n_o           (dut_oe_n),
      .ee_wr_i              (ee_wr),
      .ee_addr_i            (ee_addr),
      .ee_data_i            (ee_data),
      .ee_done_i            (ee_done),
      .signal_loss_first_i  (loss_a),
      .signal_loss_second_i (loss_b),
      .transmit_off_pin_i   (tx_pin),
      .cont_talk_first_o    (outs[4]),
      .cont_talk_second_o   (outs[3]),
      .signal_loss_o        (outs[2]),
      .transmit_off_first_o (outs[1]),
      .transmit_off_second_o(outs[0])
   );

   rcr_host i_rcr_host (
      .clk_i     (ref_clk_i),
      .dev_addr_i({SMB_ADDR_HI, straps}),
      .sda_i     (sda_line),
      .scl_o(scl),
      .sda_o(host_sda)
   );

   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_byte(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      check_byte(what, {7'h00, exp}, {7'h00, got});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      i_rcr_host.write_reg(a, d, ok);
      check_bit("write ack", 1'b1, ok);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
      logic       ok;
      logic [7:0] d;
      i_rcr_host.read_reg(a, d, ok);
      check_bit("read ack", 1'b1, ok);
      check_byte(what, exp, d);
   endtask

   // settle time covers pin synchronisers plus the output register
   task automatic outs_chk(input logic [4:0] exp);
      repeat (8) @(negedge ref_clk_i);
      check_byte("outputs", {3'h0, exp}, {3'h0, outs});
   endtask

   task automatic step(input logic [7:0] a, input logic [7:0] d,
                       input logic la, input logic lb, input logic pin,
                       input logic [4:0] exp);
      loss_a = la;
      loss_b = lb;
      tx_pin = pin;
      wr(a, d);
      rd_chk("readback", a, d);
      outs_chk(exp);
   endtask

   // msb-first crc-8, poly 07, zero init, over 0x01, 0x02, 0x04
   function automatic logic [7:0] crc8(input logic [23:0] bytes);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ bytes[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction

   initial begin
      repeat (100000) @(posedge ref_clk_i);
      fail_count++;
      $display("[ERR] run time expected done seen hung");
      finish_test();
   end

   initial begin
      reset_n_i = 1'b0;
      straps = STRAPS;
      ee_wr = 1'b0;
      ee_addr = 8'h00;
      ee_data = 8'h00;
      ee_done = 1'b0;
      loss_a = 1'b0;
      loss_b = 1'b0;
      tx_pin = 1'b0;
      fail_count = 0;
      check_count = 0;
      repeat (16) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      rd_chk("id", REG_STRAP_LOAD, {1'b0, STRAPS, 3'b100});
      rd_chk("ctl1", REG_IDLE_LOSS, RST_IDLE_LOSS);
      rd_chk("ctl2", REG_LOSS_OVR_PD, RST_LOSS_OVR_PD);
      rd_chk("ctl3", REG_MODE_TXOFF, RST_MODE_TXOFF);
      rd_chk("crc", REG_SLAVE_CRC_LO, RST_SLAVE_CRC_LO);
      rd_chk("crcctl", REG_CRC_CTRL, RST_CRC_CTRL);
      rd_chk("unmapped", 8'h03, 8'h00);
      outs_chk(5'b00000);
      $display("test reset values done");
      ee_addr = REG_IDLE_LOSS;
      ee_data = 8'hc0;
      ee_wr = 1'b1;
      @(negedge ref_clk_i);
      ee_wr = 1'b0;
      outs_chk(5'b11000);
      ee_done = 1'b1;
      @(negedge ref_clk_i);
      ee_done = 1'b0;
      rd_chk("id done", REG_STRAP_LOAD, {1'b0, STRAPS, 3'b000});
      wr(REG_STRAP_LOAD, 8'hff);
      rd_chk("id ro", REG_STRAP_LOAD, {1'b1, STRAPS, 3'b000});
      $display("test preload and id done");
      wr(REG_CRC_CTRL, 8'h18);
      step(REG_IDLE_LOSS, 8'h80, 0, 0, 0, 5'b10000);
      step(REG_IDLE_LOSS, 8'h40, 0, 0, 0, 5'b01000);
      step(REG_IDLE_LOSS, 8'h04, 1, 0, 0, 5'b00000);
      step(REG_IDLE_LOSS, 8'h04, 0, 1, 0, 5'b00100);
      step(REG_IDLE_LOSS, 8'h00, 0, 1, 0, 5'b00000);
      step(REG_IDLE_LOSS, 8'h00, 1, 0, 0, 5'b00100);
      step(REG_LOSS_OVR_PD, 8'h20, 0, 0, 0, 5'b00100);
      step(REG_LOSS_OVR_PD, 8'h30, 1, 0, 0, 5'b00000);
      step(REG_LOSS_OVR_PD, 8'h10, 1, 0, 0, 5'b00100);
      step(REG_MODE_TXOFF, 8'h30, 0, 0, 1, 5'b00010);
      step(REG_MODE_TXOFF, 8'h28, 0, 0, 1, 5'b00001);
      step(REG_MODE_TXOFF, 8'h18, 0, 0, 1, 5'b00011);
      step(REG_MODE_TXOFF, 8'h18, 0, 0, 0, 5'b00000);
      $display("test immediate writes done");
      tx_pin = 1'b1;
      wr(REG_CRC_CTRL, 8'h10);
      wr(REG_IDLE_LOSS, 8'hc0);
      wr(REG_MODE_TXOFF, 8'h20);
      outs_chk(5'b00011);
      wr(REG_SLAVE_CRC_LO, ~crc8({8'hc0, 8'h10, 8'h20}));
      wr(REG_CRC_CTRL, 8'h11);
      outs_chk(5'b00011);
      rd_chk("trigger clears", REG_CRC_CTRL, 8'h10);
      wr(REG_SLAVE_CRC_LO, crc8({8'hc0, 8'h10, 8'h20}));
      wr(REG_CRC_CTRL, 8'h11);
      outs_chk(5'b11000);
      $display("test crc gate done");
      // straps change only while reset holds; the host follows the new address
      reset_n_i = 1'b0;
      straps = STRAPS_B;
      repeat (4) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      rd_chk("id2", REG_STRAP_LOAD, {1'b0, STRAPS_B, 3'b100});
      rd_chk("ctl1 again", REG_IDLE_LOSS, RST_IDLE_LOSS);
      outs_chk(5'b00011);
      $display("test second reset done");
      finish_test();
   end
endmodule
